// ===== core/crs_regs.svh
// Purpose: offsets, field positions, opcodes and reset values for call_return_stack_ops
// Assumes: included by bare name after the package
// Notes: definitions only
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// ==========================================================
// pc and stack
`define CRS_PC_WIDTH 21
`define CRS_PC_STEP 21'h000002
`define CRS_RESET_PC 21'h000000
`define CRS_STACK_DEPTH 31
`define CRS_RESET_BYTE 8'h00

// ==========================================================
// opcodes
`define CRS_OP_PUSH 16'h0005
`define CRS_OP_RESET 16'h00FF
`define CRS_OP_RET_INT 15'h0008
`define CRS_OP_RET_LIT 8'h0C
`define CRS_OP_REL_CALL 5'h1B

// ==========================================================
// context entry indices
`define CRS_CTX_ENTRIES 13
`define CRS_CTX_WORK 0
`define CRS_CTX_STATUS 1
`define CRS_CTX_BANK 2
`define CRS_CTX_P0H 3
`define CRS_CTX_P0L 4
`define CRS_CTX_P1H 5
`define CRS_CTX_P1L 6
`define CRS_CTX_P2H 7
`define CRS_CTX_P2L 8
`define CRS_CTX_PROD_HI 9
`define CRS_CTX_PROD_LO 10
`define CRS_CTX_PC_HI 11
`define CRS_CTX_PC_UP 12

// ==========================================================
// avalon register byte offsets and fields
`define CRS_REG_CTRL 4'h0
`define CRS_REG_STATUS 4'h4
`define CRS_REG_PC 4'h8
`define CRS_REG_CONTEXT 4'hC
`define CRS_CTRL_HOLD 0
`define CRS_ST_LEVEL_LSB 0
`define CRS_ST_EXEC_LSB 8
`define CRS_ST_IRQ_LOW_EN 16
`define CRS_ST_IRQ_HIGH_EN 17
`define CRS_ST_DISCARD 18
`endif

// ===== core/crs_pkg.sv
// Purpose: types shared by the call/return execution block
// Assumes: nothing
// Notes: constants live in crs_regs.svh
package crs_pkg;
   // execution state field encoding
   typedef enum logic [1:0] {
      EXEC_MAIN = 2'h0,
      EXEC_LOW = 2'h1,
      EXEC_HIGH = 2'h2,
      EXEC_HIGH_OVER_LOW = 2'h3
   } exec_state_t;

   typedef enum logic [2:0] {
      OP_OTHER,
      OP_PUSH,
      OP_REL_CALL,
      OP_RESET,
      OP_RET_INT,
      OP_RET_LIT
   } op_kind_t;
endpackage

// ===== core/return_stack.sv
// Purpose: hardware return stack with a registered top entry
// Assumes: push and pop never asserted together
// Notes: push at full depth and pop when empty are ignored
`timescale 1ns/100ps
`default_nettype none
module return_stack #(
   parameter int DEPTH = 31,
   parameter int AW = 21
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic clear,
   input wire logic push,
   input wire logic pop,
   input wire logic [AW-1:0] push_data,
   output logic [AW-1:0] top_q,
   output logic [4:0] level_q
);
   // deeper entries only; the top sits in its own flop so pops need no read latency
   logic [AW-1:0] mem_q [0:DEPTH-2];

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         top_q <= '0;
         level_q <= 5'h00;
         for (int i = 0; i < DEPTH - 1; i++) begin
            mem_q[i] <= '0;
         end
      end else if (clk_en) begin
         if (clear) begin
            top_q <= '0;
            level_q <= 5'h00;
         end else if (push && level_q != 5'(DEPTH)) begin
            if (level_q != 5'h00) begin
               mem_q[level_q - 5'h01] <= top_q;
            end
            top_q <= push_data;
            level_q <= level_q + 5'h01;
         end else if (pop && level_q != 5'h00) begin
            top_q <= (level_q >= 5'h02) ? mem_q[level_q - 5'h02] : '0;
            level_q <= level_q - 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ===== core/call_return_stack_ops.sv
// Purpose: executes push, relative call, software reset, interrupt return and literal return
// Assumes: instr_word is the word at pc_q; irq inputs come from same-clock logic
// Notes: registers reached over avalon-mm with one wait cycle
`timescale 1ns/100ps
`default_nettype none
`include "crs_regs.svh"

// What this block does
// RULE1: push writes pc plus 2 as the new stack top, pushing the old top down, with no flag change.
// RULE2: relative call takes a signed 11-bit word offset from -1024 to 1023.
// RULE3: relative call pushes pc plus 2 first and then adds twice the offset.
// RULE4: the call target is the call address plus 2 plus twice the signed offset.
// RULE5: the reset instruction returns every register and flag to its master-clear value.
// RULE6: interrupt return pops the stack and loads the popped top into the pc.
// RULE7: with select 1 interrupt return copies the shadow set into all thirteen context registers.
// RULE8: with select 0 interrupt return touches no register from the shadow copies.
// RULE9: interrupt return sets the high or low global enable in the same cycle as the pc pop.
// RULE10: two shadow sets, main and low, exist and the one matching the state returned to is restored (low only from high-over-low).
// RULE11: interrupt return updates only the two-bit execution state field and one global enable among status flags.
// RULE12: literal return loads its 8-bit operand into the working register.
// RULE13: literal return pops the stack into the pc and changes no status flag.
// RULE14: literal return leaves the upper and high pc latches unchanged.
// RULE15: literal return is decoded from a top byte of 0000 1100 with the literal below.
// RULE16: every two-cycle transfer discards the prefetched word and runs a no-op cycle.
module call_return_stack_ops #(
   parameter int STACK_DEPTH = `CRS_STACK_DEPTH
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic irq_enter,
   input wire logic irq_high,
   input wire logic [20:0] irq_vector,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata_q,
   output logic avs_waitrequest_q,
   output logic [20:0] pc_q,
   output logic fetch_discard_q,
   output logic soft_reset_q,
   output logic [20:0] stack_top_entry,
   output logic [4:0] stack_level,
   output logic global_irq_enable_high_q,
   output logic global_irq_enable_low_q,
   output crs_pkg::exec_state_t exec_state_q,
   output logic [7:0] working_register,
   output logic [7:0] status_reg,
   output logic [7:0] bank_select_reg,
   output logic [7:0] pointer0_high,
   output logic [7:0] pointer0_low,
   output logic [7:0] pointer1_high,
   output logic [7:0] pointer1_low,
   output logic [7:0] pointer2_high,
   output logic [7:0] pointer2_low,
   output logic [7:0] product_high,
   output logic [7:0] product_low,
   output logic [7:0] pc_high_latch,
   output logic [7:0] pc_upper_latch
);
   // ==========================================================
   // decode
   crs_pkg::op_kind_t op;
   logic hold_q;
   logic go;
   logic irq_ok;
   logic irq_take;
   logic exec;
   logic soft_rst;
   logic xfer;
   logic restore_sel;
   logic use_low_set;
   logic [20:0] pc_next_seq;
   logic [20:0] call_offset;
   logic [7:0] ctx_q [0:`CRS_CTX_ENTRIES-1];
   logic [7:0] shadow_main_q [0:`CRS_CTX_ENTRIES-1];
   logic [7:0] shadow_low_q [0:`CRS_CTX_ENTRIES-1];

   always_comb begin
      op = crs_pkg::OP_OTHER;
      if (instr_word == `CRS_OP_PUSH) begin
         op = crs_pkg::OP_PUSH;
      end else if (instr_word == `CRS_OP_RESET) begin
         op = crs_pkg::OP_RESET;
      end else if (instr_word[15:1] == `CRS_OP_RET_INT) begin
         op = crs_pkg::OP_RET_INT;
      end else if (instr_word[15:8] == `CRS_OP_RET_LIT) begin // [RULE15]
         op = crs_pkg::OP_RET_LIT;
      end else if (instr_word[15:11] == `CRS_OP_REL_CALL) begin
         op = crs_pkg::OP_REL_CALL;
      end
   end

   // high may preempt main or low; low may only preempt main
   always_comb begin
      irq_ok = 1'b0;
      unique case (exec_state_q)
         crs_pkg::EXEC_MAIN: irq_ok = 1'b1;
         crs_pkg::EXEC_LOW: irq_ok = irq_high;
         crs_pkg::EXEC_HIGH, crs_pkg::EXEC_HIGH_OVER_LOW: irq_ok = 1'b0;
      endcase
   end

   assign go = clk_en && !hold_q;
   assign irq_take = go && irq_enter && irq_ok;
   // the word behind a transfer is dropped rather than executed
   assign exec = go && !irq_take && instr_valid && !fetch_discard_q; // [RULE16]
   assign soft_rst = exec && op == crs_pkg::OP_RESET;
   assign xfer = op == crs_pkg::OP_REL_CALL || op == crs_pkg::OP_RET_INT ||
      op == crs_pkg::OP_RET_LIT;
   assign restore_sel = instr_word[0];
   assign use_low_set = exec_state_q == crs_pkg::EXEC_HIGH_OVER_LOW; // [RULE10]
   assign pc_next_seq = pc_q + `CRS_PC_STEP;
   // 11-bit signed word offset scaled to bytes
   assign call_offset = {{9{instr_word[10]}}, instr_word[10:0], 1'b0}; // [RULE2]

   // ==========================================================
   // return stack
   logic stk_push;
   logic stk_pop;
   logic [20:0] stk_data;

   assign stk_push = irq_take ||
      (exec && (op == crs_pkg::OP_PUSH || op == crs_pkg::OP_REL_CALL));
   assign stk_pop = exec && (op == crs_pkg::OP_RET_INT || op == crs_pkg::OP_RET_LIT); // [RULE6] [RULE13]
   // an interrupt returns to the word it displaced, not the one after
   assign stk_data = irq_take ? pc_q : pc_next_seq; // [RULE1] [RULE3]

   return_stack #(
      .DEPTH(STACK_DEPTH),
      .AW(`CRS_PC_WIDTH)
   ) u_stack (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clk_en(go),
      .clear(soft_rst),
      .push(stk_push),
      .pop(stk_pop),
      .push_data(stk_data),
      .top_q(stack_top_entry),
      .level_q(stack_level)
   );

   // ==========================================================
   // program counter and fetch control
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_q <= `CRS_RESET_PC;
      end else if (go) begin
         if (soft_rst) begin
            pc_q <= `CRS_RESET_PC; // [RULE5]
         end else if (irq_take) begin
            pc_q <= irq_vector;
         end else if (exec) begin
            unique case (op)
               crs_pkg::OP_REL_CALL: pc_q <= pc_next_seq + call_offset; // [RULE3] [RULE4]
               crs_pkg::OP_RET_INT, crs_pkg::OP_RET_LIT: pc_q <= stack_top_entry; // [RULE6] [RULE13]
               crs_pkg::OP_PUSH, crs_pkg::OP_OTHER, crs_pkg::OP_RESET: pc_q <= pc_next_seq;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fetch_discard_q <= 1'b0;
         soft_reset_q <= 1'b0;
      end else if (clk_en) begin
         soft_reset_q <= soft_rst;
         if (go) begin
            fetch_discard_q <= !soft_rst && (irq_take || (exec && xfer)); // [RULE16]
         end
      end
   end

   // ==========================================================
   // execution state and global enables
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         exec_state_q <= crs_pkg::EXEC_MAIN;
         global_irq_enable_high_q <= 1'b0;
         global_irq_enable_low_q <= 1'b0;
      end else if (go) begin
         if (soft_rst) begin
            exec_state_q <= crs_pkg::EXEC_MAIN;
            global_irq_enable_high_q <= 1'b0;
            global_irq_enable_low_q <= 1'b0;
         end else if (irq_take) begin
            if (irq_high) begin
               global_irq_enable_high_q <= 1'b0;
               exec_state_q <= (exec_state_q == crs_pkg::EXEC_LOW) ?
                  crs_pkg::EXEC_HIGH_OVER_LOW : crs_pkg::EXEC_HIGH;
            end else begin
               global_irq_enable_low_q <= 1'b0;
               exec_state_q <= crs_pkg::EXEC_LOW;
            end
         end else if (exec && op == crs_pkg::OP_RET_INT) begin
            // only the state field and one global enable move; other flags stay
            unique case (exec_state_q) // [RULE11]
               crs_pkg::EXEC_HIGH_OVER_LOW: exec_state_q <= crs_pkg::EXEC_LOW;
               crs_pkg::EXEC_MAIN, crs_pkg::EXEC_LOW, crs_pkg::EXEC_HIGH:
                  exec_state_q <= crs_pkg::EXEC_MAIN;
            endcase
            if (exec_state_q == crs_pkg::EXEC_LOW) begin
               global_irq_enable_low_q <= 1'b1; // [RULE9]
            end else begin
               global_irq_enable_high_q <= 1'b1; // [RULE9]
            end
         end
      end
   end

   // ==========================================================
   // context registers and their two shadow sets
   for (genvar i = 0; i < `CRS_CTX_ENTRIES; i++) begin : g_ctx
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            ctx_q[i] <= `CRS_RESET_BYTE;
            shadow_main_q[i] <= `CRS_RESET_BYTE;
            shadow_low_q[i] <= `CRS_RESET_BYTE;
         end else if (go) begin
            if (soft_rst) begin
               ctx_q[i] <= `CRS_RESET_BYTE;
               shadow_main_q[i] <= `CRS_RESET_BYTE;
               shadow_low_q[i] <= `CRS_RESET_BYTE;
            end else if (irq_take) begin
               if (exec_state_q == crs_pkg::EXEC_LOW) begin
                  shadow_low_q[i] <= ctx_q[i];
               end else begin
                  shadow_main_q[i] <= ctx_q[i];
               end
            end else if (exec && op == crs_pkg::OP_RET_INT && restore_sel) begin
               ctx_q[i] <= use_low_set ? shadow_low_q[i] : shadow_main_q[i]; // [RULE7] [RULE8]
            end else if (exec && op == crs_pkg::OP_RET_LIT && i == `CRS_CTX_WORK) begin
               // latches fall outside this branch and keep their value
               ctx_q[i] <= instr_word[7:0]; // [RULE12] [RULE14]
            end
         end
      end
   end

   assign working_register = ctx_q[`CRS_CTX_WORK];
   assign status_reg = ctx_q[`CRS_CTX_STATUS];
   assign bank_select_reg = ctx_q[`CRS_CTX_BANK];
   assign pointer0_high = ctx_q[`CRS_CTX_P0H];
   assign pointer0_low = ctx_q[`CRS_CTX_P0L];
   assign pointer1_high = ctx_q[`CRS_CTX_P1H];
   assign pointer1_low = ctx_q[`CRS_CTX_P1L];
   assign pointer2_high = ctx_q[`CRS_CTX_P2H];
   assign pointer2_low = ctx_q[`CRS_CTX_P2L];
   assign product_high = ctx_q[`CRS_CTX_PROD_HI];
   assign product_low = ctx_q[`CRS_CTX_PROD_LO];
   assign pc_high_latch = ctx_q[`CRS_CTX_PC_HI];
   assign pc_upper_latch = ctx_q[`CRS_CTX_PC_UP];

   // ==========================================================
   // avalon-mm slave
   logic [31:0] rd_d;
   logic bus_req;
   logic bus_done;

   assign bus_req = avs_read || avs_write;
   assign bus_done = bus_req && !avs_waitrequest_q;

   always_comb begin
      rd_d = 32'h00000000;
      unique case (avs_address)
         `CRS_REG_CTRL: rd_d[`CRS_CTRL_HOLD] = hold_q;
         `CRS_REG_STATUS: begin
            rd_d[`CRS_ST_LEVEL_LSB +: 5] = stack_level;
            rd_d[`CRS_ST_EXEC_LSB +: 2] = exec_state_q;
            rd_d[`CRS_ST_IRQ_LOW_EN] = global_irq_enable_low_q;
            rd_d[`CRS_ST_IRQ_HIGH_EN] = global_irq_enable_high_q;
            rd_d[`CRS_ST_DISCARD] = fetch_discard_q;
         end
         `CRS_REG_PC: rd_d[20:0] = pc_q;
         `CRS_REG_CONTEXT: rd_d = {8'h00, status_reg, bank_select_reg, working_register};
         default: rd_d = 32'h00000000;
      endcase
   end

   // one wait cycle; read data are captured while waitrequest is still high
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest_q <= 1'b1;
         avs_readdata_q <= 32'h00000000;
      end else if (clk_en) begin
         avs_waitrequest_q <= !(bus_req && avs_waitrequest_q);
         if (avs_read && avs_waitrequest_q) begin
            avs_readdata_q <= rd_d;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_q <= 1'b0;
      end else if (clk_en) begin
         if (soft_rst) begin
            hold_q <= 1'b0;
         end else if (bus_done && avs_write && avs_address == `CRS_REG_CTRL) begin
            hold_q <= avs_writedata[`CRS_CTRL_HOLD];
         end
      end
   end

   // ==========================================================
   // checks
   sequence s_xfer_exec;
      exec && xfer;
   endsequence

   sequence s_drop_cycle;
      fetch_discard_q && go && !irq_take;
   endsequence

   AST_PUSH_TOP: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE1]
      exec && op == crs_pkg::OP_PUSH && stack_level != 5'(STACK_DEPTH) |=>
      stack_top_entry == $past(pc_q) + `CRS_PC_STEP && $stable(status_reg))
      else $error("push did not place pc+2 on the stack top");

   AST_REL_CALL_TOP: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE3]
      exec && op == crs_pkg::OP_REL_CALL && stack_level != 5'(STACK_DEPTH) |=>
      stack_top_entry == $past(pc_q) + `CRS_PC_STEP)
      else $error("relative call return address wrong");

   AST_REL_CALL_PC: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE4]
      exec && op == crs_pkg::OP_REL_CALL |=>
      pc_q == $past(pc_q) + `CRS_PC_STEP + $past(call_offset))
      else $error("relative call target wrong");

   AST_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE5]
      soft_rst |=> pc_q == `CRS_RESET_PC && stack_level == 5'h00 && soft_reset_q &&
      working_register == `CRS_RESET_BYTE && !global_irq_enable_high_q)
      else $error("software reset left state behind");

   AST_RET_INT_PC: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
      exec && op == crs_pkg::OP_RET_INT |=> pc_q == $past(stack_top_entry))
      else $error("interrupt return did not load stack top");

   AST_RESTORE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE7]
      exec && op == crs_pkg::OP_RET_INT && restore_sel && use_low_set |=>
      working_register == $past(shadow_low_q[`CRS_CTX_WORK]) &&
      pc_upper_latch == $past(shadow_low_q[`CRS_CTX_PC_UP]))
      else $error("low shadow set not restored");

   AST_NO_RESTORE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE8]
      exec && op == crs_pkg::OP_RET_INT && !restore_sel |=>
      $stable(working_register) && $stable(bank_select_reg) && $stable(product_low))
      else $error("context changed without restore select");

   AST_RET_INT_ENABLE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE9]
      exec && op == crs_pkg::OP_RET_INT |=>
      (global_irq_enable_high_q || global_irq_enable_low_q) &&
      exec_state_q != $past(exec_state_q) || $past(exec_state_q) == crs_pkg::EXEC_MAIN)
      else $error("interrupt return did not re-enable interrupts");

   AST_RET_LIT: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE12]
      exec && op == crs_pkg::OP_RET_LIT |=>
      working_register == $past(instr_word[7:0]) && pc_q == $past(stack_top_entry))
      else $error("literal return wrong");

   AST_RET_LIT_LATCH: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE14]
      exec && op == crs_pkg::OP_RET_LIT |=>
      $stable(pc_high_latch) && $stable(pc_upper_latch) && $stable(status_reg))
      else $error("literal return touched a pc latch");

   AST_FLUSH: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE16]
      s_xfer_exec |=> fetch_discard_q)
      else $error("transfer did not discard prefetch");

   AST_DROP: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE16]
      s_drop_cycle |=> $stable(pc_q) && !fetch_discard_q)
      else $error("discarded word was executed");
endmodule
`default_nettype wire

// ===== tb/call_return_stack_ops_test.sv
// Purpose: self-checking bench for call_return_stack_ops
// Assumes: one avalon wait cycle, one dropped fetch after each transfer
// Notes: expected pc and stack values are tracked here by hand
`timescale 1ns/100ps
`default_nettype none
module call_return_stack_ops_test;
   logic sys_clk = 1'b0;
   logic clk_en = 1'b1;
   logic reset_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic irq_enter = 1'b0;
   logic irq_high = 1'b0;
   logic [20:0] irq_vector = 21'h000100;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata_q, rd;
   logic avs_waitrequest_q, fetch_discard_q, soft_reset_q, irq_en_hi, irq_en_lo, rst_seen;
   logic [20:0] pc_q, top;
   logic [4:0] level;
   crs_pkg::exec_state_t exec_state_q;
   logic [7:0] work_reg, pc_hi_latch, pc_up_latch;
   int failures = 0;
   int check_count = 0;

   always #2.5 sys_clk = ~sys_clk;

   call_return_stack_ops dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr_word(instr_word), .irq_enter(irq_enter),
      .irq_high(irq_high), .irq_vector(irq_vector), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata_q(avs_readdata_q), .avs_waitrequest_q(avs_waitrequest_q), .pc_q(pc_q),
      .fetch_discard_q(fetch_discard_q), .soft_reset_q(soft_reset_q), .stack_top_entry(top),
      .stack_level(level), .global_irq_enable_high_q(irq_en_hi),
      .global_irq_enable_low_q(irq_en_lo),
      .exec_state_q(exec_state_q), .working_register(work_reg), .status_reg(),
      .bank_select_reg(), .pointer0_high(), .pointer0_low(), .pointer1_high(),
      .pointer1_low(), .pointer2_high(), .pointer2_low(), .product_high(), .product_low(),
      .pc_high_latch(pc_hi_latch), .pc_upper_latch(pc_up_latch));

   // the pulse lasts one cycle after the executing edge and is gone before the check, so it is latched here
   always @(posedge sys_clk) begin
      if (soft_reset_q === 1'b1) begin
         rst_seen <= 1'b1;
      end
   end

   // ==========================================================
   // shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic exec(input logic [15:0] w, input logic exp_disc);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      @(negedge sys_clk);
      check("discard", {31'h0, fetch_discard_q}, {31'h0, exp_disc});
   endtask

   task automatic state(input logic [20:0] p, input logic [20:0] t, input logic [4:0] l);
      check("pc", {11'h0, pc_q}, {11'h0, p});
      check("top", {11'h0, top}, {11'h0, t});
      check("level", {27'h0, level}, {27'h0, l});
   endtask

   // holds the request until waitrequest is sampled low, then releases it
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest_q !== 1'b0 && n < 50);
      rd = avs_readdata_q;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         check("waitrequest", 32'h1, 32'h0);
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_push_ret_int();
      exec(16'h0005, 1'b0);
      state(21'h000002, 21'h000002, 5'h01);
      exec(16'h0010, 1'b1);
      state(21'h000002, 21'h000000, 5'h00);
      check("irq_en_hi", {31'h0, irq_en_hi}, 32'h1);
      check("state", {30'h0, exec_state_q}, 32'h0);
      check("work_reg", {24'h0, work_reg}, 32'h0);
   endtask

   task automatic t_ret_lit();
      exec(16'h0005, 1'b0);
      exec(16'h0C5A, 1'b1);
      state(21'h000004, 21'h000000, 5'h00);
      check("work_reg", {24'h0, work_reg}, 32'h5A);
      check("latches", {16'h0, pc_up_latch, pc_hi_latch}, 32'h0);
   endtask

   task automatic t_rel_call();
      exec(16'hDBFF, 1'b1);
      state(21'h000804, 21'h000006, 5'h01);
      exec(16'hDC00, 1'b1);
      state(21'h000006, 21'h000806, 5'h02);
   endtask

   task automatic t_irq_restore();
      @(posedge sys_clk);
      irq_high <= 1'b1;
      irq_enter <= 1'b1;
      @(posedge sys_clk);
      irq_enter <= 1'b0;
      @(negedge sys_clk);
      state(21'h000100, 21'h000006, 5'h03);
      exec(16'h0005, 1'b0);
      exec(16'h0C33, 1'b1);
      check("work_reg", {24'h0, work_reg}, 32'h33);
      exec(16'h0011, 1'b1);
      state(21'h000006, 21'h000806, 5'h02);
      check("work_reg", {24'h0, work_reg}, 32'h5A);
      check("irq_en_hi", {31'h0, irq_en_hi}, 32'h1);
      check("state", {30'h0, exec_state_q}, 32'h0);
   endtask

   task automatic t_avalon();
      bus(1'b0, 4'h8, 32'h0);
      check("pc_reg", rd, 32'h00000006);
      bus(1'b0, 4'h4, 32'h0);
      check("status_reg", rd, 32'h00020002);
      bus(1'b0, 4'hC, 32'h0);
      check("context_reg", rd, 32'h0000005A);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'b1, 4'h0, 32'h00000001);
      exec(16'h0005, 1'b0);
      state(21'h000006, 21'h000806, 5'h02);
      bus(1'b1, 4'h0, 32'h00000000);
      // clock enable low must freeze execution just as hold does
      clk_en <= 1'b0;
      exec(16'h0005, 1'b0);
      state(21'h000006, 21'h000806, 5'h02);
      @(posedge sys_clk);
      clk_en <= 1'b1;
   endtask

   task automatic t_reset();
      rst_seen = 1'b0;
      exec(16'h00FF, 1'b0);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check("soft_reset", {31'h0, rst_seen}, 32'h1);
      state(21'h000000, 21'h000000, 5'h00);
      check("work_reg", {24'h0, work_reg}, 32'h0);
      check("irq_en_hi", {31'h0, irq_en_hi}, 32'h0);
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_push_ret_int();
      t_ret_lit();
      t_rel_call();
      t_irq_restore();
      t_avalon();
      t_reset();
      print_verdict();
   end

   initial begin
      repeat (2000) @(posedge sys_clk);
      failures++;
      print_verdict();
   end
endmodule
`default_nettype wire
